// *** src/sdram_pkg.sv ***
/*
  Shared constants and types for the synchronous DRAM device model:
  command encodings, mode field positions, burst states and the write
  entry that travels through the write buffer.
  Assumes a single 40 MHz system clock; all users import the whole package.
*/
package sdram_pkg;

  // Array geometry
  localparam int ROW_W  = 12;
  localparam int COL_W  = 9;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int BANKS  = 4;

  // Mode word field positions and the precharge-all bit on the address lines
  localparam int MODE_BLEN_LSB    = 0;
  localparam int MODE_TYPE_BIT    = 3;
  localparam int MODE_LAT_LSB     = 4;
  localparam int MODE_WSINGLE_BIT = 9;
  localparam int PRECHARGE_ALL_BIT = 10;

  // Burst length and read latency codes
  localparam logic [2:0] BLEN_1    = 3'h0;
  localparam logic [2:0] BLEN_2    = 3'h1;
  localparam logic [2:0] BLEN_4    = 3'h2;
  localparam logic [2:0] BLEN_8    = 3'h3;
  localparam logic [2:0] BLEN_PAGE = 3'h7;
  localparam logic [2:0] LAT_TWO   = 3'h2;
  localparam logic [2:0] LAT_THREE = 3'h3;
  localparam logic [COL_W-1:0] COL_FULL = 9'h1FF;

  // Initialisation, timing and default sizes
  localparam logic [3:0] INIT_REFRESHES   = 4'h8;
  localparam int CLK_PERIOD_NS            = 25;
  localparam int REFRESH_BUSY_NS          = 100;
  localparam int REFRESH_BUSY_CYCLES =
    (REFRESH_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_STORE_BITS_DEF = 2;
  localparam int WR_FIFO_DEPTH      = 8;

  typedef struct packed {
    logic       write_single;
    logic [2:0] latency;
    logic       interleave;
    logic [2:0] blen;
  } mode_t;

  // Power-up contents are undefined; this value is arbitrary
  localparam mode_t MODE_RESET = '{1'b0, LAT_TWO, 1'b0, BLEN_1};

  typedef enum logic [2:0] {
    CMD_MRS  = 3'h0,
    CMD_REF  = 3'h1,
    CMD_PRE  = 3'h2,
    CMD_ACT  = 3'h3,
    CMD_WR   = 3'h4,
    CMD_RD   = 3'h5,
    CMD_STOP = 3'h6,
    CMD_NOP  = 3'h7
  } cmd_t;

  typedef enum logic [1:0] {
    B_IDLE  = 2'h0,
    B_READ  = 2'h1,
    B_WRITE = 2'h3
  } burst_state_t;

  typedef enum logic [1:0] {
    PWR_RUN          = 2'h0,
    PWR_DOWN         = 2'h1,
    PWR_SUSPEND      = 2'h3,
    PWR_SELF_REFRESH = 2'h2
  } power_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic [DATA_W-1:0] data;
    logic [1:0]        mask;
  } wr_entry_t;

endpackage

// *** src/wr_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides, used to queue write
  words on their way into the storage array.
  Assumes one clock; the clock enable freezes every flip-flop.
*/
`timescale 1ns/100ps
module wr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             ce_in,
  input  wire logic             push_valid_in,
  output logic                  push_ready_out,
  input  wire logic [WIDTH-1:0] push_data_in,
  output logic                  pop_valid_out,
  input  wire logic             pop_ready_in,
  output logic [WIDTH-1:0]      pop_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      fill;
  logic             do_push;
  logic             do_pop;

  // Handshakes are combinational from the fill level
  assign push_ready_out = (fill != (PW+1)'(DEPTH));
  assign pop_valid_out  = (fill != '0);
  assign pop_data_out   = store[rd_ptr];
  assign do_push = ce_in && push_valid_in && push_ready_out;
  assign do_pop  = ce_in && pop_valid_out && pop_ready_in;

  // Wrapping pointer step, shared by both ends
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Storage has no reset; only pointers and fill level carry control state
  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      store[wr_ptr] <= push_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= step(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= step(rd_ptr);
      end
      if (do_push && !do_pop) begin
        fill <= fill + 1'b1;
      end else if (do_pop && !do_push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule

// *** src/sdram_command_and_init_interface.sv ***
/*
  Synchronous DRAM device core: command decode, bank tracking, mode word,
  burst column counter, read latency pipeline with byte masks, write
  buffer into a reduced storage array, and power state from clock enable.
  Assumes a memory controller drives the strobes synchronously to
  sys_clk_in and joins data_lines_out/oe with data_lines_in on the wire.
*/
// Function
// - Bursts of 1, 2, 4, 8 or full page within an open row.
// - Burst columns after the first come from an internal counter.
// - A new column address is accepted on every clock cycle.
// - Read latency programmable as two or three cycles.
// - Twelve-bit row at activate, nine-bit column on low lines.
// - Two bank inputs pick one of four banks; words are 16 bits.
// - Chip select high ignores commands; running burst continues.
// - Row, column and write strobes decode the operation each edge.
// - Read byte mask high floats that byte two cycles later.
// - Write byte mask high blocks that byte in the same cycle.
// - Clock enable low freezes state: power down, suspend or self refresh.
// - Mode sets burst length, read latency and burst ordering.
// - Separate low and high byte masks for the data word.
// - Mode option for burst reads with single-word writes.
// - All four strobes low loads the mode from the address lines.
`timescale 1ns/100ps
module sdram_command_and_init_interface import sdram_pkg::*; #(
  parameter int ROW_STORE_BITS = ROW_STORE_BITS_DEF,
  parameter int FIFO_DEPTH     = WR_FIFO_DEPTH,
  parameter int REFRESH_BUSY   = REFRESH_BUSY_CYCLES
) (
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  input  wire logic              cke_in,
  input  wire logic              cs_n_in,
  input  wire logic              ras_n_in,
  input  wire logic              cas_n_in,
  input  wire logic              we_n_in,
  input  wire logic [ROW_W-1:0]  mux_address_lines_in,
  input  wire logic [BANK_W-1:0] bank_pick_inputs_in,
  input  wire logic              low_byte_mask_in,
  input  wire logic              high_byte_mask_in,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0]      data_lines_out,
  output logic [DATA_W-1:0]      data_lines_oe_out,
  output logic                   write_ready_out,
  output logic                   mode_valid_out,
  output logic                   init_done_out,
  output power_t                 power_state_out
);
  localparam int IDX_W = BANK_W + ROW_STORE_BITS + COL_W;
  // Busy counter follows the parameter, so long busy times are not cut
  localparam int BUSY_W = $clog2(REFRESH_BUSY + 2);

  cmd_t              cmd;
  mode_t             mode;
  logic [BANKS-1:0]  bank_open;
  logic [ROW_W-1:0]  open_row [BANKS];
  burst_state_t      burst_state;
  logic [BANK_W-1:0] burst_bank;
  logic [COL_W-1:0]  burst_start;
  logic [COL_W-1:0]  burst_cnt;
  logic [COL_W-1:0]  burst_mask_r;
  logic              rd_beat;
  logic              wr_beat;
  logic              burst_end;
  logic [BANK_W-1:0] beat_bank;
  logic [COL_W-1:0]  beat_col;
  logic [DATA_W-1:0] store [1 << IDX_W];
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] rd_s0;
  logic [DATA_W-1:0] rd_s1;
  logic              rd_v0;
  logic              rd_v1;
  logic [1:0]        mask_d;
  logic              pre_all_seen;
  logic [3:0]        ref_count;
  logic [BUSY_W-1:0] refresh_busy;
  logic              cke_d;
  wr_entry_t         push_entry;
  wr_entry_t         pop_entry;
  logic              push_valid;
  logic              pop_valid;
  logic              pop_ready;

  // Mask of column bits that a burst of this length walks through
  function automatic logic [COL_W-1:0] blen_mask(input logic [2:0] code);
    case (code)
      BLEN_1:    return 9'h000;
      BLEN_2:    return 9'h001;
      BLEN_4:    return 9'h003;
      BLEN_8:    return 9'h007;
      BLEN_PAGE: return COL_FULL;
      default:   return 9'h000;
    endcase
  endfunction

  // Column of beat n: sequential add or interleaved flip, inside the wrap
  function automatic logic [COL_W-1:0] beat_column(
    input logic [COL_W-1:0] start, input logic [COL_W-1:0] n,
    input logic [COL_W-1:0] msk, input logic ilv);
    logic [COL_W-1:0] low;
    low = ilv ? (start ^ n) : COL_W'(start + n);
    return (low & msk) | (start & ~msk);
  endfunction

  // Storage index; only the low row bits are kept to bound the array
  function automatic logic [IDX_W-1:0] store_index(
    input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
    input logic [COL_W-1:0] c);
    return {b, r[ROW_STORE_BITS-1:0], c};
  endfunction

  // Strobe decode; chip select high reads as no-operation
  assign cmd = cs_n_in ? CMD_NOP
                       : cmd_t'({ras_n_in, cas_n_in, we_n_in});

  // Which column is touched this edge: new command wins over counter
  always_comb begin
    rd_beat   = 1'b0;
    wr_beat   = 1'b0;
    burst_end = 1'b0;
    beat_bank = burst_bank;
    beat_col  = beat_column(burst_start, burst_cnt, burst_mask_r,
                            mode.interleave);
    case (cmd)
      CMD_RD: begin
        rd_beat   = 1'b1;
        beat_bank = bank_pick_inputs_in;
        beat_col  = mux_address_lines_in[COL_W-1:0];
      end
      CMD_WR: begin
        wr_beat   = 1'b1;
        beat_bank = bank_pick_inputs_in;
        beat_col  = mux_address_lines_in[COL_W-1:0];
      end
      CMD_STOP: burst_end = 1'b1;
      CMD_PRE: begin
        burst_end = mux_address_lines_in[PRECHARGE_ALL_BIT] ||
                    (bank_pick_inputs_in == burst_bank);
        rd_beat   = !burst_end && (burst_state == B_READ);
        wr_beat   = !burst_end && (burst_state == B_WRITE);
      end
      default: begin
        rd_beat = (burst_state == B_READ);
        wr_beat = (burst_state == B_WRITE);
      end
    endcase
  end

  // Burst sequencer; full page runs until stopped or interrupted
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      burst_state  <= B_IDLE;
      burst_bank   <= '0;
      burst_start  <= '0;
      burst_cnt    <= '0;
      burst_mask_r <= '0;
    end else if (cke_in) begin
      if (cmd == CMD_RD || cmd == CMD_WR) begin
        burst_bank  <= bank_pick_inputs_in;
        burst_start <= mux_address_lines_in[COL_W-1:0];
        burst_cnt   <= 9'h001;
        if (cmd == CMD_WR && mode.write_single) begin
          burst_mask_r <= 9'h000;
          burst_state  <= B_IDLE;
        end else begin
          burst_mask_r <= blen_mask(mode.blen);
          burst_state  <= (mode.blen == BLEN_1) ? B_IDLE
                        : (cmd == CMD_RD) ? B_READ : B_WRITE;
        end
      end else if (burst_end) begin
        burst_state <= B_IDLE;
      end else if (burst_state != B_IDLE) begin
        burst_cnt <= COL_W'(burst_cnt + 1'b1);
        if (burst_cnt == burst_mask_r && burst_mask_r != COL_FULL) begin
          burst_state <= B_IDLE;
        end
      end
    end
  end

  // Bank activation and precharge
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bank_open <= '0;
      for (int i = 0; i < BANKS; i++) begin
        open_row[i] <= '0;
      end
    end else if (cke_in) begin
      if (cmd == CMD_ACT) begin
        bank_open[bank_pick_inputs_in] <= 1'b1;
        open_row[bank_pick_inputs_in]  <= mux_address_lines_in;
      end else if (cmd == CMD_PRE) begin
        if (mux_address_lines_in[PRECHARGE_ALL_BIT]) begin
          bank_open <= '0;
        end else begin
          bank_open[bank_pick_inputs_in] <= 1'b0;
        end
      end
    end
  end

  // Mode word, initialisation tracking and refresh occupancy
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode           <= MODE_RESET;
      mode_valid_out <= 1'b0;
      pre_all_seen   <= 1'b0;
      ref_count      <= '0;
      refresh_busy   <= '0;
    end else if (cke_in) begin
      if (cmd == CMD_MRS) begin
        mode.blen  <= mux_address_lines_in[MODE_BLEN_LSB +: 3];
        mode.interleave   <= mux_address_lines_in[MODE_TYPE_BIT];
        mode.latency      <= mux_address_lines_in[MODE_LAT_LSB +: 3];
        mode.write_single <= mux_address_lines_in[MODE_WSINGLE_BIT];
        mode_valid_out    <= 1'b1;
      end
      if (cmd == CMD_PRE && mux_address_lines_in[PRECHARGE_ALL_BIT]) begin
        pre_all_seen <= 1'b1;
      end
      if (cmd == CMD_REF) begin
        refresh_busy <= BUSY_W'(REFRESH_BUSY);
        if (pre_all_seen && ref_count != INIT_REFRESHES) begin
          ref_count <= ref_count + 1'b1;
        end
      end else if (refresh_busy != '0) begin
        refresh_busy <= refresh_busy - 1'b1;
      end
    end
  end

  assign init_done_out = mode_valid_out && (ref_count == INIT_REFRESHES);

  // Array read uses the open row of the beat's bank
  assign rd_word = store[store_index(beat_bank, open_row[beat_bank],
                                     beat_col)];

  // Write words queue here; a fully masked word is never queued
  assign push_valid = cke_in && wr_beat &&
                      !(low_byte_mask_in && high_byte_mask_in);
  assign push_entry = '{beat_bank, open_row[beat_bank], beat_col,
                        data_lines_in,
                        {high_byte_mask_in, low_byte_mask_in}};
  // Refresh holds the array, so the queue may fill behind it
  assign pop_ready  = (refresh_busy == '0);

  wr_fifo #(
    .WIDTH ($bits(wr_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk_in     (sys_clk_in),
    .resetn_in      (resetn_in),
    .ce_in          (cke_in),
    .push_valid_in  (push_valid),
    .push_ready_out (write_ready_out),
    .push_data_in   (push_entry),
    .pop_valid_out  (pop_valid),
    .pop_ready_in   (pop_ready),
    .pop_data_out   (pop_entry)
  );

  // Drain into the array, one byte lane per mask bit
  always_ff @(posedge sys_clk_in) begin
    if (cke_in && pop_valid && pop_ready) begin
      if (!pop_entry.mask[0]) begin
        store[store_index(pop_entry.bank, pop_entry.row,
                          pop_entry.col)][7:0] <= pop_entry.data[7:0];
      end
      if (!pop_entry.mask[1]) begin
        store[store_index(pop_entry.bank, pop_entry.row,
                          pop_entry.col)][15:8] <= pop_entry.data[15:8];
      end
    end
  end

  // Read pipeline: output register loads latency minus one edges on
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_s0             <= '0;
      rd_s1             <= '0;
      rd_v0             <= 1'b0;
      rd_v1             <= 1'b0;
      mask_d            <= 2'h3;
      data_lines_out    <= '0;
      data_lines_oe_out <= '0;
    end else if (cke_in) begin
      rd_s0  <= rd_word;
      rd_v0  <= rd_beat;
      rd_s1  <= rd_s0;
      rd_v1  <= rd_v0;
      mask_d <= {high_byte_mask_in, low_byte_mask_in};
      data_lines_out <= (mode.latency == LAT_THREE) ? rd_s1 : rd_s0;
      // Drive only presented read data; masks float a lane
      data_lines_oe_out <= {{8{!mask_d[1]}}, {8{!mask_d[0]}}} &
        {DATA_W{(mode.latency == LAT_THREE) ? rd_v1 : rd_v0}};
    end
  end

  // Power state keeps running while clock enable is low, on purpose
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cke_d           <= 1'b1;
      power_state_out <= PWR_RUN;
    end else begin
      cke_d <= cke_in;
      if (cke_in) begin
        power_state_out <= PWR_RUN;
      end else if (cke_d) begin
        power_state_out <= (burst_state != B_IDLE || rd_v0 || rd_v1)
                           ? PWR_SUSPEND
                           : (cmd == CMD_REF) ? PWR_SELF_REFRESH : PWR_DOWN;
      end
    end
  end

  // Checks
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  a_read_latency_two: assert property (
    (cke_in && cmd == CMD_RD && !low_byte_mask_in &&
     mode.latency == LAT_TWO) ##1 cke_in |=> data_lines_oe_out[0])
    else $error("read data late at latency two");
  a_read_latency_three: assert property (
    (cke_in && cmd == CMD_RD && !low_byte_mask_in &&
     mode.latency == LAT_THREE) ##1 (cke_in && !low_byte_mask_in)
    ##1 cke_in |=> data_lines_oe_out[0])
    else $error("read data late at latency three");
  a_mask_read_float: assert property (
    (cke_in && high_byte_mask_in) ##1 cke_in |=> !data_lines_oe_out[8])
    else $error("masked read byte still driven");
  a_drive_only_read: assert property (
    (cke_in && burst_state == B_IDLE && !rd_v0 && !rd_v1 && !rd_beat)
    |=> data_lines_oe_out == '0)
    else $error("data lines driven without read data");
  a_chip_select_ignore: assert property (
    (cke_in && cs_n_in && burst_state == B_IDLE)
    |=> burst_state == B_IDLE && $stable(mode))
    else $error("command taken while deselected");
  a_burst_four_start: assert property (
    (cke_in && cmd == CMD_RD && mode.blen == BLEN_4)
    |=> burst_state == B_READ && burst_cnt == 9'h001 &&
        burst_mask_r == 9'h003)
    else $error("burst of four not started");
  a_column_counter: assert property (
    (cke_in && burst_state == B_READ && cmd == CMD_NOP &&
     burst_cnt != burst_mask_r)
    |=> burst_cnt == COL_W'($past(burst_cnt) + 1'b1))
    else $error("burst counter did not advance");
  a_single_write_mode: assert property (
    (cke_in && cmd == CMD_WR && mode.write_single) |=> burst_state == B_IDLE)
    else $error("write burst in single write mode");
  a_write_mask_block: assert property (
    (wr_beat && low_byte_mask_in && high_byte_mask_in) |-> !push_valid)
    else $error("fully masked write was queued");
  a_mode_program: assert property (
    (cke_in && cmd == CMD_MRS) |=> mode_valid_out &&
    mode.blen == $past(mux_address_lines_in[2:0]))
    else $error("mode word not loaded");

  c_read_latency_three: cover property (
    cmd == CMD_RD && mode.latency == LAT_THREE ##3 data_lines_oe_out != '0);
  c_write_burst_eight: cover property (
    cmd == CMD_WR && mode.blen == BLEN_8 && !mode.write_single);
  c_self_refresh: cover property (power_state_out == PWR_SELF_REFRESH);
  c_init_done: cover property ($rose(init_done_out));

endmodule

// *** testbench/sdram_ctl_model.sv ***
/*
  Memory controller stand-in: drives clock enable, command, masks and
  write data, and resolves the shared data lines.
  Assumes the bench calls its tasks; the device reports its own enables.
*/
`timescale 1ns/100ps
module sdram_ctl_model import sdram_pkg::*; (
  input  wire logic              sys_clk_in,
  input  wire logic [DATA_W-1:0] dev_data_in,
  input  wire logic [DATA_W-1:0] dev_oe_in,
  output logic                   cke_out,
  output logic [3:0]             cmd_n_out,
  output logic [ROW_W-1:0]       addr_out,
  output logic [1:0]             mask_out,
  output logic [DATA_W-1:0]      bus_out
);
  localparam int PAUSE = 8000;
  logic [DATA_W-1:0] drive;
  logic [DATA_W-1:0] last = 16'h0000;
  logic              drv_en;
  // Released bits show the inverse of the last level, not a held value
  assign bus_out = (dev_oe_in & dev_data_in) |
                   (~dev_oe_in & (drv_en ? drive : ~last));
  // Remember the wire level of each cycle
  always @(posedge sys_clk_in) begin
    last <= bus_out;
  end
  // Power-up state of every controller output
  initial begin
    cke_out = 1'b1;
    cmd_n_out = 4'h7;
    addr_out = 12'h000;
    mask_out = 2'h3;
    drive = 16'h0000;
    drv_en = 1'b0;
  end
  // Clock enable moves on the same edge as the command it goes with
  task automatic set_cke(input logic v);
    cke_out <= v;
  endtask
  // One command per cycle, {cs, ras, cas, we}, launched after an edge
  task automatic issue(input logic [3:0] c, input logic [ROW_W-1:0] a,
                       input logic [1:0] m, input logic [DATA_W-1:0] d,
                       input logic e);
    @(posedge sys_clk_in);
    cmd_n_out <= c;
    addr_out <= a;
    mask_out <= m;
    drive <= d;
    drv_en <= e;
  endtask
  // Full 200 us pause kept: the device would not notice a shorter one
  task automatic init_seq(input logic [ROW_W-1:0] mw);
    repeat (PAUSE) issue(4'h7, 12'h000, 2'h3, 16'h0000, 1'b0);
    issue(4'h2, 12'h400, 2'h0, 16'h0000, 1'b0);
    repeat (8) issue(4'h1, 12'h000, 2'h0, 16'h0000, 1'b0);
    issue(4'h0, mw, 2'h0, 16'h0000, 1'b0);
    issue(4'h7, 12'h000, 2'h0, 16'h0000, 1'b0);
  endtask
endmodule

// *** testbench/sdram_command_and_init_interface_test.sv ***
/*
  Self-checking bench for the DRAM device core: init, burst write and
  read, byte masks, latency, deselect, write buffer and power states.
  Assumes sdram_ctl_model plays the controller on the far side.
*/
`timescale 1ns/100ps
module sdram_command_and_init_interface_test;
  import sdram_pkg::*;
  logic              sys_clk_in;
  logic              resetn_in;
  logic              cke;
  logic [3:0]        cmd_n;
  logic [ROW_W-1:0]  addr;
  logic [1:0]        mask;
  logic [DATA_W-1:0] bus;
  logic [DATA_W-1:0] dq;
  logic [DATA_W-1:0] oe;
  logic              wready;
  logic              mvalid;
  logic              idone;
  power_t            pwr;
  int                n_mismatch = 0;
  int                num_checks = 0;
  int                cycles = 0;

  // Long refresh busy time lets the write buffer fill
  sdram_command_and_init_interface #(.REFRESH_BUSY(20)) dut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .cke_in(cke),
    .cs_n_in(cmd_n[3]), .ras_n_in(cmd_n[2]), .cas_n_in(cmd_n[1]),
    .we_n_in(cmd_n[0]), .mux_address_lines_in(addr),
    .bank_pick_inputs_in(2'h1), .low_byte_mask_in(mask[0]),
    .high_byte_mask_in(mask[1]), .data_lines_in(bus),
    .data_lines_out(dq), .data_lines_oe_out(oe),
    .write_ready_out(wready), .mode_valid_out(mvalid),
    .init_done_out(idone), .power_state_out(pwr));

  sdram_ctl_model ctl (
    .sys_clk_in(sys_clk_in), .dev_data_in(dq), .dev_oe_in(oe),
    .cke_out(cke), .cmd_n_out(cmd_n), .addr_out(addr),
    .mask_out(mask), .bus_out(bus));

  // 40 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // Hang guard, well above the 8000-cycle pause plus tests
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Mode word with all banks closed first, then bank 1 row 3 reopened
  task automatic md(input logic [2:0] lat, input logic [2:0] bl);
    ctl.issue(4'h2, 12'h400, 2'h0, 16'h0000, 1'b0);
    ctl.issue(4'h0, {5'h00, lat, 1'b0, bl}, 2'h0, 16'h0000, 1'b0);
    ctl.issue(4'h3, 12'h003, 2'h0, 16'h0000, 1'b0);
    ctl.issue(4'h7, 12'h000, 2'h0, 16'h0000, 1'b0);
  endtask

  // Write burst of n words from column 2, low byte masked on beat mb
  task automatic wr(input int n, input logic [15:0] b, input int mb);
    for (int k = 0; k < n; k++) begin
      ctl.issue(k == 0 ? 4'h4 : 4'h7, 12'h002, {1'b0, k == mb},
                b + 16'(k), 1'b1);
    end
    ctl.issue(4'h7, 12'h000, 2'h0, 16'h0000, 1'b0);
  endtask

  // Burst-4 read at column 2; beat 1 kept the low byte of the first write
  task automatic rd(input int lat, input logic m);
    logic [15:0] eo;
    ctl.issue(4'h5, 12'h002, {1'b0, m}, 16'h0000, 1'b0);
    ctl.issue(4'h7, 12'h000, 2'h0, 16'h0000, 1'b0);
    repeat (lat - 1) @(posedge sys_clk_in);
    for (int k = 0; k < 4; k++) begin
      @(negedge sys_clk_in);
      eo = (m && k == 0) ? 16'hFF00 : 16'hFFFF;
      chk("oe", eo, oe);
      chk("data", (k == 1 ? 16'hB001 : 16'hB0F0 + 16'(k)) & eo,
          dq & eo);
    end
    @(negedge sys_clk_in);
    chk("oe idle", 16'h0000, oe);
  endtask

  initial begin
    resetn_in = 1'b0;
    repeat (12) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    resetn_in = 1'b1;
    ctl.init_seq({5'h00, LAT_TWO, 1'b0, BLEN_4});
    @(negedge sys_clk_in);
    chk("mode valid", 16'h0001, {15'h0, mvalid});
    chk("init done", 16'h0001, {15'h0, idone});
    ctl.issue(4'h3, 12'h003, 2'h0, 16'h0000, 1'b0);
    wr(4, 16'hA000, 9);
    wr(4, 16'hB0F0, 1);
    repeat (30) @(posedge sys_clk_in);
    md(LAT_THREE, BLEN_4);
    rd(3, 1'b0);
    md(LAT_TWO, BLEN_4);
    rd(2, 1'b1);
    // Deselected read must leave the lines released
    ctl.issue(4'hD, 12'h002, 2'h0, 16'h0000, 1'b0);
    ctl.issue(4'h7, 12'h000, 2'h0, 16'h0000, 1'b0);
    repeat (4) begin
      @(negedge sys_clk_in);
      chk("oe deselect", 16'h0000, oe);
    end
    // Refresh stalls the array while eight words pile up
    md(LAT_TWO, BLEN_8);
    // Run is far shorter than one refresh interval; this only stalls
    ctl.issue(4'h1, 12'h000, 2'h0, 16'h0000, 1'b0);
    wr(8, 16'hC000, 9);
    @(negedge sys_clk_in);
    chk("ready full", 16'h0000, {15'h0, wready});
    repeat (40) @(negedge sys_clk_in);
    chk("ready drained", 16'h0001, {15'h0, wready});
    // Full page read from column 2, cut by a burst stop on its fourth edge
    md(LAT_TWO, BLEN_PAGE);
    ctl.issue(4'h5, 12'h002, 2'h0, 16'h0000, 1'b0);
    repeat (2) ctl.issue(4'h7, 12'h000, 2'h0, 16'h0000, 1'b0);
    ctl.issue(4'h6, 12'h000, 2'h0, 16'h0000, 1'b0);
    ctl.issue(4'h7, 12'h000, 2'h0, 16'h0000, 1'b0);
    @(negedge sys_clk_in);
    chk("page data", 16'hC002, dq);
    @(negedge sys_clk_in);
    chk("oe stop", 16'h0000, oe);
    // Clock enable low: power down when idle, self refresh on refresh
    for (int i = 0; i < 2; i++) begin
      ctl.issue(i ? 4'h1 : 4'h7, 12'h000, 2'h0, 16'h0000, 1'b0);
      ctl.set_cke(1'b0);
      @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      chk("power", {14'h0, i ? PWR_SELF_REFRESH : PWR_DOWN},
          {14'h0, pwr});
      ctl.issue(4'h7, 12'h000, 2'h0, 16'h0000, 1'b0);
      ctl.set_cke(1'b1);
      @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      chk("power run", {14'h0, PWR_RUN}, {14'h0, pwr});
    end
    conclude();
  end
endmodule
